// *** core/fsps_cfg.svh ***
`ifndef FSPS_CFG_SVH
`define FSPS_CFG_SVH

// ==========================================================
// Register byte offsets
`define FSPS_OFS_CTL 8'h00
`define FSPS_OFS_PTR 8'h04
`define FSPS_OFS_DATA 8'h08
`define FSPS_OFS_OP 8'h0c
`define FSPS_OFS_LOAD 8'h10

// ==========================================================
// Control and status bit positions
`define FSPS_B_ARM 0
`define FSPS_B_ERS 1
`define FSPS_B_WRT 2
`define FSPS_B_LCK 3
`define FSPS_B_REEN 4
`define FSPS_B_BUSY 6
`define FSPS_B_IE 7

// Operation register bits
`define FSPS_OP_STORE 0
`define FSPS_OP_LOAD 1

// Command patterns on control bits 4..0, bit 7 ignored
`define FSPS_CMD_ERASE 5'h03
`define FSPS_CMD_FILL 5'h01
`define FSPS_CMD_WRITE 5'h05
`define FSPS_CMD_LOCK 5'h09
`define FSPS_CMD_REEN 5'h11

// Fuse and lock readback pointer values
`define FSPS_Z_FUSE_LO 16'h0000
`define FSPS_Z_LOCK 16'h0001
`define FSPS_Z_FUSE_EXT 16'h0002
`define FSPS_Z_FUSE_HI 16'h0003

// ==========================================================
// Reset values and timing
`define FSPS_LOCK_RST 6'h3f
`define FSPS_APP_VECTOR 15'h0000
`define FSPS_STORE_WIN 3'h4
`define FSPS_LOAD_WIN 3'h3
`define FSPS_CLK_PERIOD_NS 5
`define FSPS_PROG_MIN_NS 3700000
`define FSPS_TMR_W 20

`endif

// *** core/fsps_page_buf.sv ***
`timescale 1ns/100ps
`default_nettype none

module fsps_page_buf #(
    parameter int WIDTH = 16,
    parameter int ABITS = 6
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic we,
    input wire logic [ABITS-1:0] waddr,
    input wire logic [WIDTH-1:0] wdata,
    input wire logic [ABITS-1:0] raddr,
    output logic [WIDTH-1:0] rdata
);

    typedef struct packed {
        logic [(1<<ABITS)-1:0][WIDTH-1:0] mem;
        logic [WIDTH-1:0] q;
    } fsps_buf_t;

    fsps_buf_t st_r;
    fsps_buf_t st_nxt;

    // ======================================================
    // Write port and registered read
    always_comb begin
        st_nxt = st_r;
        if (we) begin
            st_nxt.mem[waddr] = wdata;
        end
        st_nxt.q = st_r.mem[raddr];
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            st_r.q <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign rdata = st_r.q;

endmodule // fsps_page_buf

`default_nettype wire

// *** core/fsps_pkg.sv ***
`default_nettype none

package fsps_pkg;

    // Sequencer states
    typedef enum logic [1:0] {
        FSPS_IDLE,
        FSPS_STREAM,
        FSPS_WAIT
    } fsps_state_t;

    // Kind of programming operation in flight
    typedef enum logic [1:0] {
        FSPS_K_ERASE,
        FSPS_K_WRITE,
        FSPS_K_LOCK
    } fsps_kind_t;

endpackage

`default_nettype wire

// *** core/fsps_sequencer.sv ***
//
// Notes on behaviour
// - Boot vector fuse at 0 selects boot start vector, else address zero.
// - Fuses are inputs only; software can never alter them.
// - Pointer high bits pick the page, low bits the word in page.
// - Target page is latched when an operation starts.
// - Erase pattern plus store within four cycles erases the pointer page.
// - Fill pattern plus store puts data word into buffer slot.
// - Buffer clears after page write, on re-enable, and on reset.
// - An EEPROM write during page loading discards the loaded buffer.
// - Write pattern plus store programs buffer into the pointer page.
// - Protected page work halts the CPU; concurrent page work does not.
// - Erase or write blocks concurrent reads and sets the busy flag.
// - Interrupt holds high while enabled and arm bit is clear.
// - Lock pattern programs lock bits whose data bit is zero.
// - Lock programming leaves the whole flash readable.
// - EEPROM write blocks programming and fuse or lock readback.
// - Pointer 1 with lock access armed makes a load return lock bits.
// - Lock access and arm clear on readback or window expiry.
// - Pointer 0 returns fuse low byte, pointer 3 fuse high byte.
// - Loads use the pointer as byte address, bit 0 picks the byte.
// - Pointer 2 returns the extended fuse byte, low three bits.
// - Programmed fuse and lock bits read zero, unprogrammed read one.
//
`timescale 1ns/100ps
`default_nettype none
`include "fsps_cfg.svh"

module fsps_sequencer #(
    parameter int WORD_BITS = 6,
    parameter int PAGE_BITS = 8,
    parameter logic [PAGE_BITS-1:0] PROT_PAGE = 8'he0,
    parameter logic [14:0] BOOT_VECTOR = 15'h3800,
    parameter int PROG_CYCLES =
        (`FSPS_PROG_MIN_NS + `FSPS_CLK_PERIOD_NS - 1) / `FSPS_CLK_PERIOD_NS
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic [31:0] hrdata,
    output logic hresp,
    input wire logic boot_vector_fuse,
    input wire logic [7:0] fuse_low_byte,
    input wire logic [7:0] fuse_high_byte,
    input wire logic [2:0] fuse_extended_byte,
    input wire logic eeprom_write_active,
    input wire logic [15:0] flash_rd_word,
    output logic [14:0] flash_rd_addr,
    output logic [14:0] reset_vector,
    output logic flash_erase,
    output logic flash_write,
    output logic [PAGE_BITS-1:0] flash_page,
    output logic flash_wr_en,
    output logic [WORD_BITS-1:0] flash_wr_word,
    output logic [15:0] flash_wr_data,
    output logic cpu_halt,
    output logic section_read_block,
    output logic selfprog_irq
);

    localparam int NW = 1 << WORD_BITS;
    localparam int TW = `FSPS_TMR_W;

    typedef struct packed {
        logic [7:0] ctl;
        logic [2:0] win;
        logic [15:0] z;
        logic [15:0] dat;
        logic [7:0] load;
        logic [5:0] lock;
        logic [NW-1:0] valid;
        fsps_pkg::fsps_state_t st;
        fsps_pkg::fsps_kind_t kind;
        logic [PAGE_BITS-1:0] pg;
        logic [WORD_BITS-1:0] idx;
        logic [TW-1:0] tmr;
        logic ap_valid;
        logic ap_wr;
        logic [7:0] ap_addr;
        logic [31:0] hrdata;
        logic [14:0] rd_addr;
        logic [14:0] rst_vec;
        logic vec_done;
        logic fl_erase;
        logic fl_write;
        logic fl_wen;
        logic [WORD_BITS-1:0] fl_word;
        logic halt;
        logic irq;
        logic ee_prev;
    } fsps_state_reg_t;

    fsps_state_reg_t s_r;
    fsps_state_reg_t s_nxt;

    logic buf_we;
    logic [WORD_BITS-1:0] buf_raddr;

    // ======================================================
    // Helpers
    function automatic logic in_concurrent(
        input logic [PAGE_BITS-1:0] page
    );
        in_concurrent = page < PROT_PAGE;
    endfunction

    function automatic logic [PAGE_BITS-1:0] page_of(input logic [15:0] z);
        page_of = z[WORD_BITS+PAGE_BITS:WORD_BITS+1];
    endfunction

    // ======================================================
    // Temporary page buffer
    fsps_page_buf #(
        .WIDTH(16),
        .ABITS(WORD_BITS)
    ) u_buf (
        .sys_clk(sys_clk),
        .rst(rst),
        .we(buf_we),
        .waddr(s_r.z[WORD_BITS:1]),
        .wdata(s_r.dat),
        .raddr(buf_raddr),
        .rdata(flash_wr_data)
    );

    // ======================================================
    // Next state
    always_comb begin
        logic wr_dp;
        logic [4:0] cmd;
        logic armed;
        logic ee;
        logic [PAGE_BITS-1:0] zp;
        s_nxt = s_r;
        wr_dp = s_r.ap_valid && s_r.ap_wr;
        cmd = s_r.ctl[4:0];
        armed = s_r.ctl[`FSPS_B_ARM];
        ee = eeprom_write_active;
        zp = page_of(s_r.z);
        buf_we = 1'b0;
        buf_raddr = s_r.idx;
        s_nxt.fl_wen = 1'b0;
        s_nxt.ee_prev = ee;

        // Reset vector caught once after reset release
        if (!s_r.vec_done) begin
            s_nxt.vec_done = 1'b1;
            s_nxt.rst_vec = boot_vector_fuse ? `FSPS_APP_VECTOR
                                             : BOOT_VECTOR;
        end

        // Arm window counter, saturating
        if (s_r.win != 3'h7) begin
            s_nxt.win = s_r.win + 3'h1;
        end

        // Auto-clear of arm and select bits when windows lapse
        if (s_r.st == fsps_pkg::FSPS_IDLE && armed
            && s_r.win >= `FSPS_STORE_WIN) begin
            s_nxt.ctl[4:0] = 5'h00;
        end

        // Bus address phase: capture and prepare read data
        s_nxt.ap_valid = hsel && htrans[1] && hready;
        s_nxt.ap_wr = hwrite;
        s_nxt.ap_addr = haddr[7:0];
        unique case (haddr[7:0])
            `FSPS_OFS_CTL: s_nxt.hrdata = {24'h0, s_r.ctl};
            `FSPS_OFS_PTR: s_nxt.hrdata = {16'h0, s_r.z};
            `FSPS_OFS_DATA: s_nxt.hrdata = {16'h0, s_r.dat};
            `FSPS_OFS_LOAD: s_nxt.hrdata = {24'h0, s_r.load};
            default: s_nxt.hrdata = 32'h0;
        endcase

        // Bus data phase writes
        if (wr_dp) begin
            unique case (s_r.ap_addr)
                `FSPS_OFS_CTL: begin
                    // Writes refused while an operation is in flight (not idle) or EEPROM is writing
                    if (s_r.st == fsps_pkg::FSPS_IDLE && !ee) begin
                        s_nxt.ctl[4:0] = hwdata[4:0];
                        s_nxt.ctl[`FSPS_B_IE] = hwdata[`FSPS_B_IE];
                        s_nxt.win = 3'h0;
                    end
                end
                `FSPS_OFS_PTR: s_nxt.z = hwdata[15:0];
                `FSPS_OFS_DATA: s_nxt.dat = hwdata[15:0];
                `FSPS_OFS_OP: begin
                    if (hwdata[`FSPS_OP_STORE] && armed && !ee
                        && s_r.st == fsps_pkg::FSPS_IDLE
                        && s_r.win < `FSPS_STORE_WIN) begin
                        s_nxt.ctl[4:0] = 5'h00;
                        s_nxt.pg = zp;
                        s_nxt.idx = '0;
                        s_nxt.tmr = TW'(PROG_CYCLES - 1);
                        unique case (cmd)
                            `FSPS_CMD_ERASE: begin
                                s_nxt.ctl[`FSPS_B_ARM] = 1'b1;
                                s_nxt.kind = fsps_pkg::FSPS_K_ERASE;
                                s_nxt.st = fsps_pkg::FSPS_WAIT;
                                s_nxt.fl_erase = 1'b1;
                                s_nxt.ctl[`FSPS_B_BUSY] = 1'b1;
                                s_nxt.halt = !in_concurrent(zp);
                            end
                            `FSPS_CMD_WRITE: begin
                                s_nxt.ctl[`FSPS_B_ARM] = 1'b1;
                                s_nxt.kind = fsps_pkg::FSPS_K_WRITE;
                                s_nxt.st = fsps_pkg::FSPS_STREAM;
                                s_nxt.fl_write = 1'b1;
                                s_nxt.ctl[`FSPS_B_BUSY] = 1'b1;
                                s_nxt.halt = !in_concurrent(zp);
                            end
                            `FSPS_CMD_LOCK: begin
                                // No busy flag: flash stays readable
                                s_nxt.ctl[`FSPS_B_ARM] = 1'b1;
                                s_nxt.kind = fsps_pkg::FSPS_K_LOCK;
                                s_nxt.st = fsps_pkg::FSPS_WAIT;
                            end
                            `FSPS_CMD_FILL: begin
                                buf_we = 1'b1;
                                s_nxt.valid[s_r.z[WORD_BITS:1]] = 1'b1;
                            end
                            `FSPS_CMD_REEN: begin
                                s_nxt.ctl[`FSPS_B_BUSY] = 1'b0;
                                s_nxt.valid = '0;
                            end
                            default: begin
                            end
                        endcase
                    end else if (hwdata[`FSPS_OP_LOAD]) begin
                        if (armed && s_r.ctl[`FSPS_B_LCK]
                            && s_r.win < `FSPS_LOAD_WIN) begin
                            // Fuse and lock readback; fuses are only read
                            if (!ee) begin
                                unique case (s_r.z)
                                    `FSPS_Z_LOCK:
                                        s_nxt.load = {2'b11, s_r.lock};
                                    `FSPS_Z_FUSE_LO:
                                        s_nxt.load = fuse_low_byte;
                                    `FSPS_Z_FUSE_HI:
                                        s_nxt.load = fuse_high_byte;
                                    `FSPS_Z_FUSE_EXT:
                                        s_nxt.load = {5'h1f,
                                                      fuse_extended_byte};
                                    default: s_nxt.load = 8'hff;
                                endcase
                            end
                            s_nxt.ctl[4:0] = 5'h00;
                        end else if (s_r.ctl[`FSPS_B_BUSY]
                                     && in_concurrent(zp)) begin
                            s_nxt.load = 8'hff;
                        end else begin
                            s_nxt.load = s_r.z[0] ? flash_rd_word[15:8]
                                                  : flash_rd_word[7:0];
                        end
                    end
                end
                default: begin
                end
            endcase
        end

        // Read address follows the pointer as a word address
        s_nxt.rd_addr = s_nxt.z[15:1];

        // EEPROM write start during loading drops the buffer
        if (ee && !s_r.ee_prev && s_r.st == fsps_pkg::FSPS_IDLE) begin
            s_nxt.valid = '0;
        end

        // Programming sequence
        unique case (s_r.st)
            fsps_pkg::FSPS_IDLE: begin
            end
            fsps_pkg::FSPS_STREAM: begin
                // Hand each loaded buffer word to the array; unloaded ones are skipped
                s_nxt.fl_wen = s_r.valid[s_r.idx];
                s_nxt.fl_word = s_r.idx;
                s_nxt.idx = s_r.idx + 1'b1;
                if (s_r.idx == WORD_BITS'(NW - 1)) begin
                    s_nxt.st = fsps_pkg::FSPS_WAIT;
                end
            end
            fsps_pkg::FSPS_WAIT: begin
                s_nxt.tmr = s_r.tmr - 1'b1;
                if (s_r.tmr == '0) begin
                    s_nxt.st = fsps_pkg::FSPS_IDLE;
                    s_nxt.ctl[`FSPS_B_ARM] = 1'b0;
                    s_nxt.fl_erase = 1'b0;
                    s_nxt.fl_write = 1'b0;
                    s_nxt.halt = 1'b0;
                    if (s_r.kind == fsps_pkg::FSPS_K_WRITE) begin
                        s_nxt.valid = '0;
                    end
                    if (s_r.kind == fsps_pkg::FSPS_K_LOCK) begin
                        s_nxt.lock = s_r.lock & s_r.dat[5:0];
                    end
                end
            end
        endcase

        // Completion interrupt level
        s_nxt.irq = s_nxt.ctl[`FSPS_B_IE]
                    && !s_nxt.ctl[`FSPS_B_ARM];
    end

    // ======================================================
    // State register
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            s_r <= '0;
            s_r.lock <= `FSPS_LOCK_RST;
            s_r.st <= fsps_pkg::FSPS_IDLE;
            s_r.kind <= fsps_pkg::FSPS_K_ERASE;
            s_r.rst_vec <= `FSPS_APP_VECTOR;
        end else begin
            s_r <= s_nxt;
        end
    end

    // ======================================================
    // Outputs from registers; bus ready and response tied constant
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign hrdata = s_r.hrdata;
    assign flash_rd_addr = s_r.rd_addr;
    assign reset_vector = s_r.rst_vec;
    assign flash_erase = s_r.fl_erase;
    assign flash_write = s_r.fl_write;
    assign flash_page = s_r.pg;
    assign flash_wr_en = s_r.fl_wen;
    assign flash_wr_word = s_r.fl_word;
    assign cpu_halt = s_r.halt;
    assign section_read_block = s_r.ctl[`FSPS_B_BUSY];
    assign selfprog_irq = s_r.irq;

endmodule // fsps_sequencer

`default_nettype wire

// *** dv/flash_self_program_sequencer_tb_top.sv ***
`timescale 1ns/100ps
`default_nettype none
`include "fsps_cfg.svh"

module flash_self_program_sequencer_tb_top;
    logic sys_clk = 0, rst = 1, hwrite = 0, boot_vector_fuse = 0;
    logic eeprom_write_active = 0;
    logic [1:0] htrans = 0;
    logic [31:0] haddr = 0, hwdata = 0, q;
    logic [7:0] fuse_low_byte = 8'h5a, fuse_high_byte = 8'hc3;
    logic [2:0] fuse_extended_byte = 3'h5;
    wire logic hreadyout, hresp, flash_erase, flash_write, flash_wr_en;
    wire logic cpu_halt, section_read_block, selfprog_irq;
    wire logic [31:0] hrdata;
    wire logic [15:0] flash_rd_word, flash_wr_data;
    wire logic [14:0] flash_rd_addr, reset_vector;
    wire logic [7:0] flash_page;
    wire logic [5:0] flash_wr_word;
    int err_count = 0, samples_checked = 0, cyc = 0;
    localparam logic [15:0] PG = 16'h0180; // Page 3, word 0

    fsps_sequencer #(.PROG_CYCLES(20)) u_dut (.sys_clk, .rst, .hsel(1'b1),
        .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata, .hready(hreadyout),
        .hreadyout, .hrdata, .hresp, .boot_vector_fuse, .fuse_low_byte,
        .fuse_high_byte, .fuse_extended_byte, .eeprom_write_active,
        .flash_rd_word, .flash_rd_addr, .reset_vector, .flash_erase,
        .flash_write, .flash_page, .flash_wr_en, .flash_wr_word,
        .flash_wr_data, .cpu_halt, .section_read_block, .selfprog_irq);
    fsps_flash_model u_flash (.sys_clk, .flash_erase, .flash_page,
        .flash_wr_en, .flash_wr_word, .flash_wr_data, .flash_rd_addr,
        .flash_rd_word);

    // ==========================================================
    // Clock and hang guard
    initial begin
        forever #2.5 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            err_count++;
            print_verdict();
        end
    end

    task automatic print_verdict();
        $display("Checks %0d, mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask

    // ==========================================================
    // Bus tasks, entered just after a rising edge
    task automatic bus(input logic w, input logic [7:0] a,
            input logic [31:0] d, output logic [31:0] r);
        haddr <= {24'h0, a};
        hwrite <= w;
        htrans <= 2'b10;
        do @(posedge sys_clk); while (hreadyout !== 1'b1);
        htrans <= 2'b00;
        hwdata <= d;
        do @(posedge sys_clk); while (hreadyout !== 1'b1);
        r = hrdata;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        bus(1'b1, a, d, r);
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        samples_checked++;
        if (g !== e) begin
            err_count++;
            $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    // Pointer, control and operation written back to back
    task automatic cmd(input logic [15:0] p, input logic [7:0] c,
            input logic [1:0] o);
        wr(`FSPS_OFS_PTR, {16'h0, p});
        wr(`FSPS_OFS_CTL, {24'h0, c});
        wr(`FSPS_OFS_OP, {30'h0, o});
    endtask
    task automatic ld(input logic [15:0] p, input logic [7:0] c,
            input logic [7:0] e);
        logic [31:0] r;
        cmd(p, c, 2'b10);
        bus(1'b0, `FSPS_OFS_LOAD, 32'h0, r);
        chk(r & 32'hff, {24'h0, e});
    endtask
    // Poll until the arm bit drops
    task automatic wait_arm();
        logic [31:0] r;
        r = 32'h1;
        for (int n = 0; n < 200 && r[0] !== 1'b0; n++)
            bus(1'b0, `FSPS_OFS_CTL, 32'h0, r);
        chk(32'(r[0]), 32'h0);
    endtask

    // ==========================================================
    // Main sequence
    initial begin
        repeat (6) @(posedge sys_clk);
        rst <= 1'b0;
        repeat (2) @(posedge sys_clk);
        chk(32'(reset_vector), 32'h3800);
        // Word 7 loaded, then lost to an eeprom write
        wr(`FSPS_OFS_DATA, 32'haaaa);
        cmd(PG | 16'h000e, 8'h01, 2'b01);
        eeprom_write_active <= 1'b1;
        wr(`FSPS_OFS_CTL, 32'h09);
        bus(1'b0, `FSPS_OFS_CTL, 32'h0, q);
        chk(q & 32'h1f, 32'h0);
        chk(32'(hresp), 32'h0);
        eeprom_write_active <= 1'b0;
        wr(`FSPS_OFS_DATA, 32'h1234);
        cmd(PG, 8'h01, 2'b01);
        wr(`FSPS_OFS_DATA, 32'hbeef);
        cmd(PG | 16'h000a, 8'h01, 2'b01);
        // Erase with bit 7 set, then check busy and interrupt
        cmd(PG, 8'h83, 2'b01);
        wait_arm();
        chk(32'(selfprog_irq), 32'h1);
        chk(32'(section_read_block), 32'h1);
        ld(PG | 16'h0001, 8'h00, 8'hff);
        chk(32'(selfprog_irq), 32'h0);
        cmd(PG, 8'h85, 2'b01);
        wait_arm();
        // Written page holds 0x1234 here, so only the block gives 0xff
        ld(PG, 8'h00, 8'hff);
        cmd(16'h0000, 8'h11, 2'b01);
        wait_arm();
        chk(32'(section_read_block), 32'h0);
        ld(PG, 8'h00, 8'h34);
        ld(PG | 16'h000b, 8'h00, 8'hbe);
        ld(PG | 16'h000e, 8'h00, 8'hff);
        // Erase in the protected section
        cmd(16'h7080, 8'h03, 2'b01);
        wait_arm();
        cmd(16'h0000, 8'h11, 2'b01);
        wait_arm();
        // Lock programming keeps the whole flash readable
        wr(`FSPS_OFS_DATA, 32'hea);
        cmd(16'h0001, 8'h89, 2'b01);
        wait_arm();
        chk(32'(section_read_block), 32'h0);
        ld(16'h0000, 8'h09, 8'h5a);
        ld(16'h0001, 8'h09, 8'hea);
        ld(16'h0002, 8'h09, 8'hfd);
        ld(16'h0003, 8'h09, 8'hc3);
        bus(1'b0, `FSPS_OFS_CTL, 32'h0, q);
        chk(q & 32'h1f, 32'h0);
        // Armed readback left to expire
        wr(`FSPS_OFS_CTL, 32'h09);
        repeat (6) @(posedge sys_clk);
        bus(1'b0, `FSPS_OFS_CTL, 32'h0, q);
        chk(q & 32'h1f, 32'h0);
        // Second reset with the fuse unprogrammed
        rst <= 1'b1;
        boot_vector_fuse <= 1'b1;
        repeat (6) @(posedge sys_clk);
        rst <= 1'b0;
        repeat (2) @(posedge sys_clk);
        chk(32'(reset_vector), 32'h0000);
        ld(16'h0001, 8'h09, 8'hff);
        print_verdict();
    end
endmodule // flash_self_program_sequencer_tb_top

bind fsps_sequencer fsps_seq_assertions u_chk (.sys_clk, .rst,
    .boot_vector_fuse, .eeprom_write_active, .reset_vector, .flash_erase,
    .flash_write, .flash_page, .flash_wr_en, .cpu_halt, .section_read_block,
    .selfprog_irq);

`default_nettype wire

// *** dv/fsps_flash_model.sv ***
`timescale 1ns/100ps
`default_nettype none

// ==========================================================
// Flash array model standing behind the sequencer
module fsps_flash_model (
    input wire logic sys_clk,
    input wire logic flash_erase,
    input wire logic [7:0] flash_page,
    input wire logic flash_wr_en,
    input wire logic [5:0] flash_wr_word,
    input wire logic [15:0] flash_wr_data,
    input wire logic [14:0] flash_rd_addr,
    output logic [15:0] flash_rd_word
);
    logic [15:0] mem [0:32767];

    // Array starts fully erased
    initial begin
        for (int i = 0; i < 32768; i++) mem[i] = 16'hffff;
    end

    // Erase sets the whole page, a stream word lands at page and slot
    always @(posedge sys_clk) begin
        if (flash_erase) begin
            for (int i = 0; i < 64; i++) mem[{flash_page, 6'(i)}] <= 16'hffff;
        end
        if (flash_wr_en) mem[{flash_page, flash_wr_word}] <= flash_wr_data;
    end

    // Read path is combinational, as from the array
    assign flash_rd_word = mem[flash_rd_addr];
endmodule // fsps_flash_model

`default_nettype wire

// *** dv/fsps_seq_assertions.sv ***
`timescale 1ns/100ps
`default_nettype none

// ==========================================================
// Port checker for the sequencer
module fsps_seq_assertions (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic boot_vector_fuse,
    input wire logic eeprom_write_active,
    input wire logic [14:0] reset_vector,
    input wire logic flash_erase,
    input wire logic flash_write,
    input wire logic [7:0] flash_page,
    input wire logic flash_wr_en,
    input wire logic cpu_halt,
    input wire logic section_read_block,
    input wire logic selfprog_irq
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);

    // Erase holds for a run of cycles, then ends in bounded time
    sequence ers_hold;
        flash_erase [*8];
    endsequence
    sequence ers_end;
        !flash_erase;
    endsequence

    // Programming in progress this cycle; the page, halt and busy checks below need it for two cycles running
    wire logic prog_now = flash_erase || flash_write;

    reset_vec_a: assert property (!$past(rst) |-> reset_vector ==
        (boot_vector_fuse ? 15'h0000 : 15'h3800))
        else $error("reset vector wrong");
    page_hold_a: assert property (prog_now && $past(prog_now) |->
        $stable(flash_page)) else $error("page moved in operation");
    erase_len_a: assert property ($rose(flash_erase) |->
        ers_hold ##[1:1000] ers_end) else $error("erase length wrong");
    wren_write_a: assert property (flash_wr_en |-> flash_write)
        else $error("word write outside page write");
    halt_prot_a: assert property (prog_now && $past(prog_now) |->
        cpu_halt == (flash_page >= 8'he0)) else $error("halt wrong");
    busy_block_a: assert property (prog_now && $past(prog_now) |->
        section_read_block) else $error("section not blocked");
    irq_off_a: assert property (prog_now |-> !selfprog_irq)
        else $error("irq during operation");
    ee_block_a: assert property ($rose(prog_now) |->
        !$past(eeprom_write_active)) else $error("op during eeprom");
endmodule // fsps_seq_assertions

`default_nettype wire
